// *** isr_pkg.sv ***
// package: register map, field positions and carriers for the irq status block
`default_nettype none
package isr_pkg;

   localparam int unsigned ADDR_W = 32;
   localparam int unsigned DATA_W = 16;

   localparam logic [31:0] SYS_STATUS_ADDR   = 32'h0b00_0080;
   localparam logic [31:0] TOUCH_STATUS_ADDR = 32'h0b00_0082;
   localparam logic [31:0] AUDIO_STATUS_ADDR = 32'h0b00_0084;
   localparam logic [31:0] KEY_STATUS_ADDR   = 32'h0b00_0086;

   localparam logic [15:0] STATUS_RESET = 16'h0000;

   // live field widths; everything above reads as zero
   localparam int unsigned TOUCH_W = 5;
   localparam int unsigned AUDIO_W = 4;
   localparam int unsigned KEY_W   = 5;

   localparam int unsigned SYS_RSVD_W = 2;
   localparam int unsigned TOUCH_RSVD_W = DATA_W - TOUCH_W;
   localparam int unsigned AUDIO_RSVD_W = DATA_W - AUDIO_W;
   localparam int unsigned KEY_RSVD_W   = DATA_W - KEY_W;

   // level-1 bit positions
   localparam int unsigned BATTERY_BIT   = 0;
   localparam int unsigned LONG_CLK_BIT  = 2;

   // direct level-1 sources, msb first as they sit in bits 13..8,4..0
   typedef struct packed {
      logic suspend_touch_flag;
      logic suspend_keyboard_flag;
      logic software_flag;
      logic bus_error_flag;
      logic serial_summary_flag;
      logic gpio_summary_flag;
      logic card_slot_flag;
      logic extra_timer_flag;
      logic long_interval_clock_flag;
      logic power_switch_flag;
      logic battery_flag;
   } isr_direct_t;

   typedef struct packed {
      logic touch_dma_second_page_flag;
      logic touch_dma_first_page_flag;
      logic touch_data_lost_flag;
      logic touch_dma_done_flag;
      logic touch_contact_change_flag;
   } isr_touch_t;

   typedef struct packed {
      logic audio_dma_second_page_flag;
      logic audio_dma_first_page_flag;
      logic audio_sequencer_idle_flag;
      logic audio_sequencer_start_flag;
   } isr_audio_t;

   typedef struct packed {
      logic keyboard_dma_second_page_flag;
      logic keyboard_dma_first_page_flag;
      logic key_scan_lost_flag;
      logic key_scan_done_flag;
      logic key_press_detect_flag;
   } isr_key_t;

   typedef struct packed {
      logic line0;
      logic line1;
      logic nmi;
   } isr_lines_t;

endpackage

`default_nettype wire

// *** isr_irq_status.sv ***
// interrupt status registers of the interrupt collector
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - system status 16 bits, top two zero
// - bits 13,12 flag suspend-mode touch, keyboard
// - bit 11 flags software interrupt request
// - bits 10..5 bus error and unit summaries
// - bits 4..0 card, timer, clock, power, battery
// - touch status 16 bits, bits 15..5 zero
// - touch bits 4,3 dma page boundaries
// - touch bit 2 data lost, 1 dma end
// - touch bit 0 contact state change
// - audio status 16 bits, bits 15..4 zero
// - audio bits 3,2 dma page boundaries
// - audio bit 1 idle, 0 start
// - keyboard status 16 bits, bits 15..5 zero
// - keyboard bits 4,3 dma page boundaries
// - keyboard bits 2..0 lost, done, detect
// - masked level-2 bits form unit summary
// - masked level-1 routed to nmi, line1, line0
// - request outputs registered on master clock
module isr_irq_status (
   input  wire logic                    i_clk,
   input  wire logic                    i_arst_n,
   input  wire isr_pkg::isr_direct_t    i_direct,
   input  wire isr_pkg::isr_touch_t     i_touch,
   input  wire isr_pkg::isr_audio_t     i_audio,
   input  wire isr_pkg::isr_key_t       i_key,
   input  wire logic [15:0]             i_sys_mask,
   input  wire logic [4:0]              i_touch_mask,
   input  wire logic [3:0]              i_audio_mask,
   input  wire logic [4:0]              i_key_mask,
   input  wire logic                    i_battery_to_nmi,
   input  wire logic                    i_rd_en,
   input  wire logic                    i_wr_en,
   input  wire logic [31:0]             i_addr,
   output logic      [15:0]             o_rd_data,
   output var isr_pkg::isr_lines_t      o_lines
);

   isr_pkg::isr_direct_t direct_s1_q;
   isr_pkg::isr_direct_t direct_q;
   isr_pkg::isr_touch_t  touch_s1_q;
   isr_pkg::isr_touch_t  touch_q;
   isr_pkg::isr_audio_t  audio_s1_q;
   isr_pkg::isr_audio_t  audio_q;
   isr_pkg::isr_key_t    key_s1_q;
   isr_pkg::isr_key_t    key_q;

   logic [15:0] sys_status;
   logic [15:0] touch_status;
   logic [15:0] audio_status;
   logic [15:0] key_status;
   logic [15:0] sys_masked;
   logic [15:0] rd_data_d;
   logic        touch_sum;
   logic        audio_sum;
   logic        key_sum;
   isr_pkg::isr_lines_t lines_d;

   // every check below samples on the master edge and sleeps during reset
   default clocking isr_main_cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);

   // sources are unit levels from other blocks; two stages guard metastability
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         direct_s1_q <= '0;
         direct_q    <= '0;
         touch_s1_q  <= '0;
         touch_q     <= '0;
         audio_s1_q  <= '0;
         audio_q     <= '0;
         key_s1_q    <= '0;
         key_q       <= '0;
      end else begin
         // level follow: bit drops once the unit withdraws
         direct_s1_q <= i_direct;
         direct_q    <= direct_s1_q;
         touch_s1_q  <= i_touch;
         touch_q     <= touch_s1_q;
         audio_s1_q  <= i_audio;
         audio_q     <= audio_s1_q;
         key_s1_q    <= i_key;
         key_q       <= key_s1_q;
      end
   end

   // level-2 registers, reserved bits tied low
   assign touch_status = {{isr_pkg::TOUCH_RSVD_W{1'b0}}, touch_q};
   assign audio_status = {{isr_pkg::AUDIO_RSVD_W{1'b0}}, audio_q};
   assign key_status   = {{isr_pkg::KEY_RSVD_W{1'b0}}, key_q};

   // level-2 words trail the unit levels by exactly the two sync stages
   a_touch_rsvd: assert property (
      touch_status[15:5] == 11'h000)
      else $error("touch reserved not zero");

   a_touch_follow: assert property (
      touch_status[4:0] == $past(i_touch, 2))
      else $error("touch bits do not follow");

   a_touch_lost: assert property (
      touch_status[2] == $past(i_touch.touch_data_lost_flag, 2))
      else $error("touch data lost bit wrong");

   a_touch_done: assert property (
      touch_status[1] == $past(i_touch.touch_dma_done_flag, 2))
      else $error("touch dma end bit wrong");

   a_touch_contact: assert property (
      $rose(i_touch.touch_contact_change_flag)
      ##1 i_touch.touch_contact_change_flag |=> touch_status[0])
      else $error("contact change not flagged");

   a_audio_rsvd: assert property (
      audio_status[15:4] == 12'h000)
      else $error("audio reserved not zero");

   a_audio_follow: assert property (
      audio_status[3:0] == $past(i_audio, 2))
      else $error("audio bits do not follow");

   a_audio_idle: assert property (
      audio_status[1] == $past(i_audio.audio_sequencer_idle_flag, 2))
      else $error("audio idle bit wrong");

   a_audio_start: assert property (
      audio_status[0] == $past(i_audio.audio_sequencer_start_flag, 2))
      else $error("audio start bit wrong");

   a_key_rsvd: assert property (
      key_status[15:5] == 11'h000)
      else $error("key reserved not zero");

   a_key_follow: assert property (
      key_status == {11'h000, $past(i_key, 2)})
      else $error("key bits do not follow");

   a_key_page: assert property (
      key_status[4:3] == $past(i_key[4:3], 2))
      else $error("key page bits wrong");

   a_key_lost: assert property (
      key_status[2] == $past(i_key.key_scan_lost_flag, 2))
      else $error("key scan lost bit wrong");

   a_key_detect: assert property (
      key_status[1:0] == $past(i_key[1:0], 2))
      else $error("key done or detect bit wrong");

   // one summary per unit from its enabled bits
   assign touch_sum = |(touch_q & i_touch_mask);
   assign audio_sum = |(audio_q & i_audio_mask);
   assign key_sum   = |(key_q & i_key_mask);

   assign sys_status = {
      {isr_pkg::SYS_RSVD_W{1'b0}},
      direct_q.suspend_touch_flag,
      direct_q.suspend_keyboard_flag,
      direct_q.software_flag,
      direct_q.bus_error_flag,
      direct_q.serial_summary_flag,
      direct_q.gpio_summary_flag,
      key_sum,
      audio_sum,
      touch_sum,
      direct_q.card_slot_flag,
      direct_q.extra_timer_flag,
      direct_q.long_interval_clock_flag,
      direct_q.power_switch_flag,
      direct_q.battery_flag
   };

   a_sys_reserved: assert property (
      sys_status[15:14] == 2'b00)
      else $error("system reserved bits not zero");

   a_suspend_touch: assert property (
      sys_status[13] == $past(i_direct.suspend_touch_flag, 2))
      else $error("suspend touch bit wrong");

   a_suspend_key: assert property (
      sys_status[12] == $past(i_direct.suspend_keyboard_flag, 2))
      else $error("suspend keyboard bit wrong");

   a_soft_flag: assert property (
      $rose(i_direct.software_flag) ##1 i_direct.software_flag
      |=> sys_status[11])
      else $error("software bit not set");

   a_soft_clear: assert property (
      $fell(i_direct.software_flag) ##1 !i_direct.software_flag
      |=> !sys_status[11])
      else $error("software bit not cleared");

   a_bus_error: assert property (
      sys_status[10] == $past(i_direct.bus_error_flag, 2))
      else $error("bus error bit wrong");

   a_unit_summary: assert property (
      sys_status[9:8] == $past(i_direct[6:5], 2))
      else $error("serial or gpio summary wrong");

   a_touch_summary: assert property (
      sys_status[5] == |($past(i_touch, 2) & i_touch_mask))
      else $error("touch summary mismatch");

   a_audio_summary: assert property (
      sys_status[6] == |($past(i_audio, 2) & i_audio_mask))
      else $error("audio summary mismatch");

   a_key_summary: assert property (
      sys_status[7] == |($past(i_key, 2) & i_key_mask))
      else $error("key summary mismatch");

   a_low_sources: assert property (
      sys_status[4:1] == $past(i_direct[4:1], 2))
      else $error("card, timer, clock or power bit wrong");

   a_battery_bit: assert property (
      $past(i_direct.battery_flag, 2) |-> sys_status[0])
      else $error("battery bit lost");

   a_battery_clear: assert property (
      !$past(i_direct.battery_flag, 2) |-> !sys_status[0])
      else $error("battery bit stuck");

   assign sys_masked = sys_status & i_sys_mask;

   always_comb begin
      lines_d.nmi   = i_battery_to_nmi & sys_masked[isr_pkg::BATTERY_BIT];
      lines_d.line1 = sys_masked[isr_pkg::LONG_CLK_BIT];
      lines_d.line0 = |(sys_masked
                        & ~(16'h0001 << isr_pkg::LONG_CLK_BIT)
                        & ~(16'h0001 << isr_pkg::BATTERY_BIT))
                      | (~i_battery_to_nmi
                         & sys_masked[isr_pkg::BATTERY_BIT]);
   end

   a_line1_route: assert property (
      sys_status[2] && i_sys_mask[2] |=> o_lines.line1)
      else $error("long clock not on line 1");

   a_line1_only: assert property (
      !sys_masked[isr_pkg::LONG_CLK_BIT] |=> !o_lines.line1)
      else $error("line 1 without long clock");

   a_nmi_route: assert property (
      sys_status[0] && i_sys_mask[0] && !i_battery_to_nmi
      |=> o_lines.line0 && !o_lines.nmi)
      else $error("battery routed wrong");

   a_nmi_select: assert property (
      sys_status[0] && i_sys_mask[0] && i_battery_to_nmi |=> o_lines.nmi)
      else $error("battery not on nmi");

   a_nmi_masked: assert property (
      !i_sys_mask[0] |=> !o_lines.nmi)
      else $error("masked battery reached nmi");

   a_line0_gather: assert property (
      |(sys_status[13:3] & i_sys_mask[13:3])
      || (sys_status[1] && i_sys_mask[1]) |=> o_lines.line0)
      else $error("line 0 missed a request");

   // read decode; writes hit nothing since every register here is read-only
   always_comb begin
      rd_data_d = isr_pkg::STATUS_RESET;
      if (!i_rd_en || i_wr_en) begin
         rd_data_d = isr_pkg::STATUS_RESET;
      end else if (i_addr == isr_pkg::SYS_STATUS_ADDR) begin
         rd_data_d = sys_status;
      end else if (i_addr == isr_pkg::TOUCH_STATUS_ADDR) begin
         rd_data_d = touch_status;
      end else if (i_addr == isr_pkg::AUDIO_STATUS_ADDR) begin
         rd_data_d = audio_status;
      end else if (i_addr == isr_pkg::KEY_STATUS_ADDR) begin
         rd_data_d = key_status;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rd_data <= isr_pkg::STATUS_RESET;
      end else begin
         o_rd_data <= rd_data_d;
      end
   end

   // read data lands one edge after the strobe and stands for that cycle only
   a_read_sys: assert property (
      i_rd_en && !i_wr_en && i_addr == isr_pkg::SYS_STATUS_ADDR
      |=> o_rd_data == $past(sys_status))
      else $error("system read data wrong");

   a_read_touch: assert property (
      i_rd_en && !i_wr_en && i_addr == isr_pkg::TOUCH_STATUS_ADDR
      |=> o_rd_data == {11'h000, $past(i_touch, 3)})
      else $error("touch read data wrong");

   a_read_audio: assert property (
      i_rd_en && !i_wr_en && i_addr == isr_pkg::AUDIO_STATUS_ADDR
      |=> o_rd_data == {12'h000, $past(i_audio, 3)})
      else $error("audio read data wrong");

   a_read_key: assert property (
      i_rd_en && !i_wr_en && i_addr == isr_pkg::KEY_STATUS_ADDR
      |=> o_rd_data == {11'h000, $past(i_key, 3)})
      else $error("key read data wrong");

   a_read_unmapped: assert property (
      i_rd_en && i_addr != isr_pkg::SYS_STATUS_ADDR
      && i_addr != isr_pkg::TOUCH_STATUS_ADDR
      && i_addr != isr_pkg::AUDIO_STATUS_ADDR
      && i_addr != isr_pkg::KEY_STATUS_ADDR |=> o_rd_data == 16'h0000)
      else $error("unmapped read returned data");

   a_write_noeff: assert property (
      i_wr_en |=> o_rd_data == 16'h0000)
      else $error("write produced read data");

   a_idle_zero: assert property (
      !i_rd_en |=> o_rd_data == 16'h0000)
      else $error("idle cycle showed read data");

   // registered so every request line changes on the rising master edge
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_lines <= '0;
      end else begin
         o_lines <= lines_d;
      end
   end

   a_lines_reg: assert property (
      !(|sys_masked) |=> o_lines == 3'b000)
      else $error("request line without cause");

   a_lines_stable: assert property (
      $stable(sys_masked) && $stable(i_battery_to_nmi) |=> $stable(o_lines))
      else $error("request lines moved without cause");

endmodule

`default_nettype wire

// *** isr_src_model.sv ***
// peripheral-unit side: request levels toward the irq status block
`timescale 1ns/1ps
`default_nettype none
module isr_src_model (
   input  wire logic            i_clk,
   input  wire logic            i_load,
   input  wire logic [24:0]     i_lvl,
   output var isr_pkg::isr_direct_t o_direct,
   output var isr_pkg::isr_touch_t  o_touch,
   output var isr_pkg::isr_audio_t  o_audio,
   output var isr_pkg::isr_key_t    o_key
);
   // levels, not pulses: a unit keeps asking until it withdraws
   initial {o_direct, o_touch, o_audio, o_key} = 25'h000_0000;
   always @(negedge i_clk) begin
      if (i_load) begin
         {o_direct, o_touch, o_audio, o_key} <= i_lvl;
      end
   end
endmodule
`default_nettype wire

// *** interrupt_status_registers_tb_top.sv ***
// self-checking bench for the irq status registers
`timescale 1ns/1ps
`default_nettype none
module interrupt_status_registers_tb_top;
   logic                 clk, arst_n, rd_en, wr_en, load, sel;
   logic [31:0]          addr;
   logic [24:0]          lvl;
   logic [15:0]          sys_mask, rd_data, e_sys;
   logic [4:0]           t_mask, k_mask;
   logic [3:0]           a_mask;
   isr_pkg::isr_direct_t d;
   isr_pkg::isr_touch_t  t;
   isr_pkg::isr_audio_t  a;
   isr_pkg::isr_key_t    k;
   isr_pkg::isr_lines_t  lines;
   int                   err_total = 0;
   int                   total_checks = 0;

   isr_src_model u_src (.i_clk(clk), .i_load(load), .i_lvl(lvl),
      .o_direct(d), .o_touch(t), .o_audio(a), .o_key(k));
   isr_irq_status DUT (.i_clk(clk), .i_arst_n(arst_n), .i_direct(d),
      .i_touch(t), .i_audio(a), .i_key(k), .i_sys_mask(sys_mask),
      .i_touch_mask(t_mask), .i_audio_mask(a_mask), .i_key_mask(k_mask),
      .i_battery_to_nmi(sel), .i_rd_en(rd_en), .i_wr_en(wr_en),
      .i_addr(addr), .o_rd_data(rd_data), .o_lines(lines));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input string nm, input logic [15:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // one idle cycle between accesses keeps each strobe a clean pulse
   task automatic rd(input string nm, input logic [31:0] ad,
                     input logic we, input logic [15:0] exp);
      @(negedge clk);
      rd_en <= 1'b1;
      wr_en <= we;
      addr <= ad;
      @(posedge clk);
      @(negedge clk);
      rd_en <= 1'b0;
      wr_en <= 1'b0;
      check(nm, rd_data, exp);
   endtask

   function automatic logic [15:0] f_sys();
      return {2'b00, d[10:5], |(k & k_mask), |(a & a_mask),
              |(t & t_mask), d[4:0]};
   endfunction

   // {line0, line1, nmi} from the masked level-1 word
   function automatic logic [15:0] f_lines(input logic [15:0] s);
      logic [15:0] m;
      m = s & sys_mask;
      return {13'h0000, |(m & 16'h3ffa) | (m[0] & ~sel), m[2], m[0] & sel};
   endfunction

   initial begin
      void'($urandom(23));
      arst_n = 1'b0;
      {rd_en, wr_en, load, sel} = 4'h0;
      addr = 32'h0000_0000;
      lvl = 25'h000_0000;
      {sys_mask, t_mask, a_mask, k_mask} = 30'h0000_0000;
      repeat (10) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      rd("sys_rst", isr_pkg::SYS_STATUS_ADDR, 1'b0, 16'h0000);
      rd("touch_rst", isr_pkg::TOUCH_STATUS_ADDR, 1'b0, 16'h0000);
      rd("audio_rst", isr_pkg::AUDIO_STATUS_ADDR, 1'b0, 16'h0000);
      rd("key_rst", isr_pkg::KEY_STATUS_ADDR, 1'b0, 16'h0000);
      for (int i = 0; i < 60; i++) begin
         @(negedge clk);
         load <= 1'b1;
         // corners: everything up, then everything withdrawn
         lvl <= (i % 4 == 0) ? 25'h1ff_ffff :
                (i % 4 == 1) ? 25'h000_0000 : 25'($urandom);
         sys_mask <= (i % 4 == 0) ? 16'hffff : 16'($urandom);
         {t_mask, a_mask, k_mask} <= 14'($urandom);
         sel <= 1'($urandom);
         @(negedge clk);
         load <= 1'b0;
         repeat (4) @(negedge clk);
         e_sys = f_sys();
         check("lines", {13'h0000, lines}, f_lines(e_sys));
         rd("sys", isr_pkg::SYS_STATUS_ADDR, 1'b0, e_sys);
         rd("touch", isr_pkg::TOUCH_STATUS_ADDR, 1'b0, {11'h000, t});
         rd("audio", isr_pkg::AUDIO_STATUS_ADDR, 1'b0, {12'h000, a});
         rd("key", isr_pkg::KEY_STATUS_ADDR, 1'b0, {11'h000, k});
         rd("unmapped", 32'h0b00_0088, 1'b0, 16'h0000);
         rd("write", isr_pkg::SYS_STATUS_ADDR, 1'b1, 16'h0000);
         rd("after_wr", isr_pkg::SYS_STATUS_ADDR, 1'b0, e_sys);
      end
      close_out();
   end

   initial begin
      #40000;
      err_total++;
      close_out();
   end
endmodule
`default_nettype wire
